// File: inc/crs_pkg.sv
//
// Behaviour
// - Sixteen general, three control, four system registers
// - Register zero is the index operand
// - Register fifteen is the exception stack pointer
// - Global base feeds base-relative addressing
// - Vector base anchors exception vector fetches
// - MAC high and low hold products
// - Return link holds subroutine return address
// - Program counter holds the executing address
// - Reset loads stack pointer from vector table
// - Reset loads program counter from vector table
// - Reset sets mask ones, clears reserved, vector base
// - Register operands are always full longwords
// - Byte and word loads are sign-extended
package crs_pkg;

  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned GEN_COUNT = 16;
  localparam int unsigned IDX_W     = 4;

  localparam logic [IDX_W-1:0] INDEX_REG_NUM = 4'h0;
  localparam logic [IDX_W-1:0] STACK_REG_NUM = 4'hf;

  // ****************************************
  // Status word layout and reset
  // ****************************************
  localparam int unsigned MASK_LSB = 4;
  localparam int unsigned MASK_W   = 4;
  localparam logic [DATA_W-1:0] STATUS_LIVE_BITS = 32'h0000_03f3;
  localparam logic [MASK_W-1:0] MASK_RESET       = 4'hf;
  localparam logic [DATA_W-1:0] VECTOR_BASE_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ZERO_WORD         = 32'h0000_0000;

  // ****************************************
  // Load widths and control and system register selectors
  // ****************************************
  typedef enum logic [1:0]
  {
    CRS_SIZE_BYTE = 2'b00,
    CRS_SIZE_WORD = 2'b01,
    CRS_SIZE_LONG = 2'b10
  } crs_size_t;

  typedef enum logic [2:0]
  {
    CRS_SEL_STATUS = 3'b000,
    CRS_SEL_GBASE  = 3'b001,
    CRS_SEL_VBASE  = 3'b010,
    CRS_SEL_MAC_HIGH   = 3'b011,
    CRS_SEL_MAC_LOW   = 3'b100,
    CRS_SEL_LINK   = 3'b101
  } crs_sel_t;

  typedef enum logic [1:0]
  {
    CRS_ST_LOAD_SP = 2'b00,
    CRS_ST_LOAD_PC = 2'b01,
    CRS_ST_RUN     = 2'b10
  } crs_state_t;

  // General register write request
  typedef struct packed
  {
    logic               en;
    logic [IDX_W-1:0]   addr;
    logic [DATA_W-1:0]  data;
    logic               from_mem;
    crs_size_t          size;
  } crs_gwrite_t;

  // Multiply result write
  typedef struct packed
  {
    logic               en_high;
    logic               en_low;
    logic [DATA_W-1:0]  high;
    logic [DATA_W-1:0]  low;
  } crs_mac_t;

endpackage : crs_pkg

// File: verilog/crs_gen_mem.sv
`timescale 1ns/1ps
// Sixteen-entry general register memory, two registered read ports
module crs_gen_mem
  import crs_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W,
  parameter int unsigned DEPTH = GEN_COUNT,
  parameter int unsigned AW    = IDX_W
)
(
  input  wire logic             clk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_a_addr,
  input  wire logic [AW-1:0]    rd_b_addr,
  output logic      [WIDTH-1:0] rd_a_data,
  output logic      [WIDTH-1:0] rd_b_data
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  // Single write port
  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem_reg[wr_addr] <= wr_data;
  end

  // Registered reads, new data bypassed on same-address write
  always_ff @(posedge clk)
  begin
    rd_a_data <= (wr_en && wr_addr == rd_a_addr) ? wr_data : mem_reg[rd_a_addr];
    rd_b_data <= (wr_en && wr_addr == rd_b_addr) ? wr_data : mem_reg[rd_b_addr];
  end

endmodule // crs_gen_mem

// File: verilog/crs_register_set.sv
`timescale 1ns/1ps
module crs_register_set
  import crs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  // Vector table values presented during reset
  input  wire logic [DATA_W-1:0] vec_stack_init,
  input  wire logic [DATA_W-1:0] vec_pc_init,
  // General register ports
  input  wire crs_gwrite_t       gen_write,
  input  wire logic [IDX_W-1:0]  rd_a_addr,
  input  wire logic [IDX_W-1:0]  rd_b_addr,
  output logic      [DATA_W-1:0] rd_a_data,
  output logic      [DATA_W-1:0] rd_b_data,
  output logic      [DATA_W-1:0] index_register,
  output logic      [DATA_W-1:0] stack_pointer,
  // Control and system register writes
  input  wire logic              ctl_wr_en,
  input  wire crs_sel_t          ctl_wr_sel,
  input  wire logic [DATA_W-1:0] ctl_wr_data,
  input  wire crs_mac_t          mac_write,
  input  wire logic              link_capture,
  input  wire logic              pc_load,
  input  wire logic [DATA_W-1:0] pc_target,
  input  wire logic              pc_advance,
  // Exception vector and base-relative address helpers
  input  wire logic [DATA_W-1:0] vector_offset,
  input  wire logic [DATA_W-1:0] gbase_disp,
  // Register views
  output logic      [DATA_W-1:0] status_word,
  output logic      [MASK_W-1:0] interrupt_mask_bits,
  output logic      [DATA_W-1:0] global_base,
  output logic      [DATA_W-1:0] vector_base,
  output logic      [DATA_W-1:0] mac_high,
  output logic      [DATA_W-1:0] mac_low,
  output logic      [DATA_W-1:0] return_link,
  output logic      [DATA_W-1:0] program_counter,
  output logic      [DATA_W-1:0] vector_addr,
  output logic      [DATA_W-1:0] gbase_addr,
  output logic                   ready
);

  // ****************************************
  // Functions
  // ****************************************

  // Widen a memory operand to a longword
  function automatic logic [DATA_W-1:0] widen(input logic [DATA_W-1:0] d, input crs_size_t s);
    logic [DATA_W-1:0] r;
    r = d;
    case (s)
      CRS_SIZE_BYTE: r = {{24{d[7]}}, d[7:0]};
      CRS_SIZE_WORD: r = {{16{d[15]}}, d[15:0]};
      default:       r = d;
    endcase
    return r;
  endfunction

  // Keep only implemented status bits, reserved read zero
  function automatic logic [DATA_W-1:0] live_status(input logic [DATA_W-1:0] d);
    return d & STATUS_LIVE_BITS;
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  crs_state_t        state_reg;
  logic              gen_wr_en;
  logic [IDX_W-1:0]  gen_wr_addr;
  logic [DATA_W-1:0] gen_wr_data;
  logic [DATA_W-1:0] mem_a;
  logic [DATA_W-1:0] mem_b;
  logic              run;

  assign run = (state_reg == CRS_ST_RUN);

  // ****************************************
  // Reset sequence
  // ****************************************

  // Load stack pointer, then program counter, then run
  always_ff @(posedge clk)
  begin
    if (reset)
      state_reg <= CRS_ST_LOAD_SP;
    else
    begin
      case (state_reg)
        CRS_ST_LOAD_SP: state_reg <= CRS_ST_LOAD_PC;
        CRS_ST_LOAD_PC: state_reg <= CRS_ST_RUN;
        default:        state_reg <= CRS_ST_RUN;
      endcase
    end
  end

  // Ready once initial values are in place
  always_ff @(posedge clk)
  begin
    if (reset)
      ready <= 1'b0;
    else
      ready <= (state_reg == CRS_ST_LOAD_PC) || run;
  end

  // ****************************************
  // General registers
  // ****************************************

  // Write port: stack pointer seeded after reset
  always_comb
  begin
    if (state_reg == CRS_ST_LOAD_SP)
    begin
      gen_wr_en   = 1'b1;
      gen_wr_addr = STACK_REG_NUM;
      gen_wr_data = vec_stack_init;
    end
    else
    begin
      gen_wr_en   = run && gen_write.en;
      gen_wr_addr = gen_write.addr;
      gen_wr_data = gen_write.from_mem ? widen(gen_write.data, gen_write.size) : gen_write.data;
    end
  end

  crs_gen_mem #(
    .WIDTH (DATA_W),
    .DEPTH (GEN_COUNT),
    .AW    (IDX_W)
  ) u_gen_mem (
    .clk       (clk),
    .wr_en     (gen_wr_en),
    .wr_addr   (gen_wr_addr),
    .wr_data   (gen_wr_data),
    .rd_a_addr (rd_a_addr),
    .rd_b_addr (rd_b_addr),
    .rd_a_data (mem_a),
    .rd_b_data (mem_b)
  );

  // Registered copies of read ports
  always_ff @(posedge clk)
  begin
    rd_a_data <= mem_a;
    rd_b_data <= mem_b;
  end

  // Shadow of the index register
  always_ff @(posedge clk)
  begin
    if (reset)
      index_register <= ZERO_WORD;
    else if (gen_wr_en && gen_wr_addr == INDEX_REG_NUM)
      index_register <= gen_wr_data;
  end

  // Shadow of the stack pointer
  always_ff @(posedge clk)
  begin
    if (reset)
      stack_pointer <= ZERO_WORD;
    else if (gen_wr_en && gen_wr_addr == STACK_REG_NUM)
      stack_pointer <= gen_wr_data;
  end

  // ****************************************
  // Control registers
  // ****************************************

  // Status word: mask set, reserved cleared at reset
  always_ff @(posedge clk)
  begin
    if (reset)
      status_word <= {{(DATA_W-MASK_LSB-MASK_W){1'b0}}, MASK_RESET, {MASK_LSB{1'b0}}};
    else if (run && ctl_wr_en && ctl_wr_sel == CRS_SEL_STATUS)
      status_word <= live_status(ctl_wr_data);
  end

  assign interrupt_mask_bits = status_word[MASK_LSB +: MASK_W];

  // Global base
  always_ff @(posedge clk)
  begin
    if (reset)
      global_base <= ZERO_WORD;
    else if (run && ctl_wr_en && ctl_wr_sel == CRS_SEL_GBASE)
      global_base <= ctl_wr_data;
  end

  // Vector base cleared at reset
  always_ff @(posedge clk)
  begin
    if (reset)
      vector_base <= VECTOR_BASE_RESET;
    else if (run && ctl_wr_en && ctl_wr_sel == CRS_SEL_VBASE)
      vector_base <= ctl_wr_data;
  end

  // Base-relative addresses, registered
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      vector_addr <= ZERO_WORD;
      gbase_addr  <= ZERO_WORD;
    end
    else
    begin
      vector_addr <= vector_base + vector_offset;
      gbase_addr  <= global_base + gbase_disp;
    end
  end

  // ****************************************
  // System registers
  // ****************************************

  // Multiply-accumulate results take priority over moves
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mac_high <= ZERO_WORD;
      mac_low  <= ZERO_WORD;
    end
    else if (run)
    begin
      if (mac_write.en_high)
        mac_high <= mac_write.high;
      else if (ctl_wr_en && ctl_wr_sel == CRS_SEL_MAC_HIGH)
        mac_high <= ctl_wr_data;
      if (mac_write.en_low)
        mac_low <= mac_write.low;
      else if (ctl_wr_en && ctl_wr_sel == CRS_SEL_MAC_LOW)
        mac_low <= ctl_wr_data;
    end
  end

  // Return link captures the current program counter, before it advances
  always_ff @(posedge clk)
  begin
    if (reset)
      return_link <= ZERO_WORD;
    else if (run && link_capture)
      return_link <= program_counter;
    else if (run && ctl_wr_en && ctl_wr_sel == CRS_SEL_LINK)
      return_link <= ctl_wr_data;
  end

  // Program counter: vector load after reset, then flow control
  always_ff @(posedge clk)
  begin
    if (reset)
      program_counter <= ZERO_WORD;
    else if (state_reg == CRS_ST_LOAD_PC)
      program_counter <= vec_pc_init;
    else if (run && pc_load)
      program_counter <= pc_target;
    else if (run && pc_advance)
      program_counter <= program_counter + 32'h0000_0002;
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_reset_status_mask: assert property (@(posedge clk) $fell(reset) |->
    status_word == 32'h0000_00f0 && vector_base == 32'h0000_0000)
    else $error("status or vector base wrong after reset");

  a_sp_from_vector: assert property (@(posedge clk) disable iff (reset)
    !reset && state_reg == CRS_ST_LOAD_SP |=> stack_pointer == $past(vec_stack_init))
    else $error("stack pointer not loaded from vector table");

  a_pc_from_vector: assert property (@(posedge clk) disable iff (reset)
    state_reg == CRS_ST_LOAD_PC |=> program_counter == $past(vec_pc_init) && ready)
    else $error("program counter not loaded from vector table");

  a_byte_sign_ext: assert property (@(posedge clk) disable iff (reset)
    run && gen_write.en && gen_write.from_mem && gen_write.size == CRS_SIZE_BYTE
    |-> gen_wr_data[31:8] == {24{gen_write.data[7]}})
    else $error("byte load not sign-extended");

  a_word_sign_ext: assert property (@(posedge clk) disable iff (reset)
    run && gen_write.en && gen_write.from_mem && gen_write.size == CRS_SIZE_WORD
    |-> gen_wr_data[31:16] == {16{gen_write.data[15]}})
    else $error("word load not sign-extended");

  a_read_two_cycle: assert property (@(posedge clk) disable iff (reset)
    run && gen_write.en && !gen_write.from_mem && rd_a_addr == gen_write.addr
    |-> ##2 rd_a_data == $past(gen_write.data, 2))
    else $error("read port A missed written value");

  a_index_shadow: assert property (@(posedge clk) disable iff (reset)
    run && gen_write.en && gen_write.addr == 4'h0 && !gen_write.from_mem
    |=> index_register == $past(gen_write.data))
    else $error("index register shadow not updated");

  a_mac_result: assert property (@(posedge clk) disable iff (reset)
    run && mac_write.en_low |=> mac_low == $past(mac_write.low))
    else $error("mac low not holding product");

  a_link_capture: assert property (@(posedge clk) disable iff (reset)
    run && link_capture |=> return_link == $past(program_counter))
    else $error("return link not captured");

  a_vector_addr: assert property (@(posedge clk) disable iff (reset)
    !reset |=> vector_addr == $past(vector_base) + $past(vector_offset))
    else $error("vector address not relative to base");

  a_pc_advance: assert property (@(posedge clk) disable iff (reset)
    run && !pc_load && pc_advance |=> program_counter == $past(program_counter) + 32'h0000_0002)
    else $error("program counter did not advance");

endmodule // crs_register_set

// File: tb/crs_vector_table.sv
`timescale 1ns/1ps
// ****************************************
// Reset vector table seen by the core
// ****************************************
module crs_vector_table
  import crs_pkg::*;
#(
  parameter logic [DATA_W-1:0] STACK_TOP = 32'h0000_fff0,
  parameter logic [DATA_W-1:0] ENTRY_PC  = 32'h0000_0400
)
(
  input  wire logic              ready,
  output logic      [DATA_W-1:0] stack_init,
  output logic      [DATA_W-1:0] pc_init
);
  // Table words only valid before run, then the fetch bus moves on
  assign stack_init = ready ? ~STACK_TOP : STACK_TOP;
  assign pc_init    = ready ? ~ENTRY_PC : ENTRY_PC;
endmodule // crs_vector_table

// File: tb/crs_register_set_bench.sv
`timescale 1ns/1ps
module crs_register_set_bench;
  import crs_pkg::*;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  localparam logic [DATA_W-1:0] SP0  = 32'h0000_fff0;
  localparam logic [DATA_W-1:0] PC0  = 32'h0000_0400;
  localparam logic [DATA_W-1:0] VOFS = 32'h0000_0040;
  localparam logic [DATA_W-1:0] GDSP = 32'h0000_0010;
  logic              clk = 1'b0;
  logic              reset, cen, lcap, pld, padv, rdy;
  logic [DATA_W-1:0] vsp, vpc, cdat, ptgt, rda, rdb, idx, sp, vofs, gdsp;
  logic [DATA_W-1:0] sw, gb, vb, mh, ml, rl, pc, va, ga;
  logic [IDX_W-1:0]  ra, rb;
  logic [MASK_W-1:0] imask;
  crs_gwrite_t       gw;
  crs_mac_t          mw;
  crs_sel_t          csel;
  int                errors = 0;
  int                tests_run = 0;

  // Clock, 40 ns period
  always #20 clk = ~clk;

  crs_vector_table #(.STACK_TOP(SP0), .ENTRY_PC(PC0)) table_model
  (
    .ready(rdy), .stack_init(vsp), .pc_init(vpc)
  );

  crs_register_set dut
  (
    .clk(clk), .reset(reset), .vec_stack_init(vsp), .vec_pc_init(vpc),
    .gen_write(gw), .rd_a_addr(ra), .rd_b_addr(rb), .rd_a_data(rda),
    .rd_b_data(rdb), .index_register(idx), .stack_pointer(sp),
    .ctl_wr_en(cen), .ctl_wr_sel(csel), .ctl_wr_data(cdat), .mac_write(mw),
    .link_capture(lcap), .pc_load(pld), .pc_target(ptgt), .pc_advance(padv),
    .vector_offset(vofs), .gbase_disp(gdsp), .status_word(sw),
    .interrupt_mask_bits(imask), .global_base(gb), .vector_base(vb),
    .mac_high(mh), .mac_low(ml), .return_link(rl), .program_counter(pc),
    .vector_addr(va), .gbase_addr(ga), .ready(rdy)
  );

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic settle;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic do_reset;
    int n;
    @(posedge clk) reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (n = 0; n < 10 && rdy !== 1'b1; n++) @(negedge clk);
    if (rdy !== 1'b1)
    begin
      errors++;
      finish_test();
    end
  endtask

  task automatic gwrite(input logic [3:0] a, input logic [31:0] d, input logic m, input crs_size_t s);
    @(posedge clk) gw <= '{en: 1'b1, addr: a, data: d, from_mem: m, size: s};
    @(posedge clk) gw.en <= 1'b0;
  endtask

  task automatic cwrite(input crs_sel_t s, input logic [31:0] d);
    @(posedge clk) cen <= 1'b1;
    csel <= s;
    cdat <= d;
    @(posedge clk) cen <= 1'b0;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [3:0] b, input logic [31:0] ea, input logic [31:0] eb);
    @(posedge clk) ra <= a;
    rb <= b;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("rd_a_data", ea, rda);
    chk("rd_b_data", eb, rdb);
  endtask

  task automatic reset_values;
    chk("status_word", 32'h0000_00f0, sw);
    chk("mask", 32'h0000_000f, {28'h0, imask});
    chk("vector_base", 32'h0000_0000, vb);
    chk("stack_pointer", SP0, sp);
    chk("program_counter", PC0, pc);
    rdchk(4'hf, 4'hf, SP0, SP0);
    $display("test reset_values done");
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    reset = 1'b1;
    gw = '0;
    mw = '0;
    {cen, lcap, pld, padv} = 4'h0;
    csel = CRS_SEL_STATUS;
    {cdat, ptgt, ra, rb} = '0;
    vofs = VOFS;
    gdsp = GDSP;
    do_reset();
    reset_values();
    // Memory loads widened, register moves kept whole
    gwrite(4'h1, 32'h0000_0080, 1'b1, CRS_SIZE_BYTE);
    gwrite(4'h2, 32'h1234_567f, 1'b1, CRS_SIZE_BYTE);
    gwrite(4'h3, 32'h0000_8000, 1'b1, CRS_SIZE_WORD);
    gwrite(4'h4, 32'h5555_7fff, 1'b1, CRS_SIZE_WORD);
    gwrite(4'h5, 32'h89ab_cdef, 1'b1, CRS_SIZE_LONG);
    gwrite(4'h6, 32'hdead_beef, 1'b0, CRS_SIZE_BYTE);
    rdchk(4'h1, 4'h2, 32'hffff_ff80, 32'h0000_007f);
    rdchk(4'h3, 4'h4, 32'hffff_8000, 32'h0000_7fff);
    rdchk(4'h5, 4'h6, 32'h89ab_cdef, 32'hdead_beef);
    gwrite(4'h0, 32'h0000_0100, 1'b0, CRS_SIZE_LONG);
    gwrite(4'hf, 32'h0000_2000, 1'b0, CRS_SIZE_LONG);
    settle();
    chk("index_register", 32'h0000_0100, idx);
    chk("stack_pointer", 32'h0000_2000, sp);
    rdchk(4'h0, 4'hf, 32'h0000_0100, 32'h0000_2000);
    // Write under an open read of the same register
    gwrite(4'h0, 32'h0000_0200, 1'b0, CRS_SIZE_LONG);
    settle();
    chk("index_register", 32'h0000_0200, idx);
    $display("test general_regs done");
    cwrite(CRS_SEL_STATUS, 32'hffff_ffff);
    cwrite(CRS_SEL_GBASE, 32'h00ff_0000);
    cwrite(CRS_SEL_VBASE, 32'h0000_8000);
    cwrite(CRS_SEL_MAC_HIGH, 32'h1111_2222);
    cwrite(CRS_SEL_MAC_LOW, 32'h3333_4444);
    cwrite(CRS_SEL_LINK, 32'h0000_0600);
    settle();
    chk("status_word", STATUS_LIVE_BITS, sw);
    chk("global_base", 32'h00ff_0000, gb);
    chk("gbase_addr", 32'h00ff_0010, ga);
    chk("vector_base", 32'h0000_8000, vb);
    chk("vector_addr", 32'h0000_8040, va);
    chk("mac_high", 32'h1111_2222, mh);
    chk("mac_low", 32'h3333_4444, ml);
    chk("return_link", 32'h0000_0600, rl);
    // New offsets follow the same bases
    @(posedge clk) vofs <= 32'h0000_0080;
    gdsp <= 32'h0000_0020;
    settle();
    chk("vector_addr", 32'h0000_8080, va);
    chk("gbase_addr", 32'h00ff_0020, ga);
    cwrite(CRS_SEL_STATUS, 32'h0000_0000);
    settle();
    chk("mask", 32'h0000_0000, {28'h0, imask});
    // Product halves written one at a time
    @(posedge clk) mw <= '{en_high: 1'b1, en_low: 1'b0, high: 32'ha5a5_0001, low: 32'h0};
    @(posedge clk) mw <= '{en_high: 1'b0, en_low: 1'b1, high: 32'h0, low: 32'h5a5a_0002};
    @(posedge clk) mw <= '0;
    settle();
    chk("mac_high", 32'ha5a5_0001, mh);
    chk("mac_low", 32'h5a5a_0002, ml);
    $display("test control_regs done");
    // Call captures the old count while it advances
    @(posedge clk) pld <= 1'b1;
    ptgt <= 32'h0000_1000;
    @(posedge clk) pld <= 1'b0;
    {lcap, padv} <= 2'b11;
    @(posedge clk) {lcap, padv} <= 2'b00;
    settle();
    chk("return_link", 32'h0000_1000, rl);
    chk("program_counter", 32'h0000_1002, pc);
    @(posedge clk) {pld, padv} <= 2'b11;
    ptgt <= 32'h0000_2000;
    @(posedge clk) {pld, padv} <= 2'b00;
    settle();
    chk("program_counter", 32'h0000_2000, pc);
    $display("test program_flow done");
    do_reset();
    reset_values();
    finish_test();
  end

  // Hang guard
  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    $display("CHECK FAILED run_length expected end seen timeout");
    finish_test();
  end
endmodule // crs_register_set_bench
